// File: src/gxp_pkg.sv
/*
  package for the eight-pin general-purpose port: register indices, field layout,
  reset values and the register-access carrier struct.
  assumes a 16-bit register port with a page bit, as seen by the device's serial front end.
*/
`default_nettype none
package gxp_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned ADDR_W    = 5;

  // register indices (shared index 10H split by page)
  localparam logic [4:0] ADDR_LEVEL    = 5'h10;
  localparam logic [4:0] ADDR_DIR      = 5'h11;
  localparam logic [4:0] ADDR_OUT_TYPE = 5'h12;
  localparam logic [4:0] ADDR_IN_STATE = 5'h13;

  localparam logic PAGE_STATUS  = 1'h0;
  localparam logic PAGE_CONTROL = 1'h1;

  // field positions
  localparam int unsigned LOW_FIELD_LSB  = 0;
  localparam int unsigned HIGH_FIELD_LSB = 8;

  // reset values
  localparam logic [7:0] DRIVE_LEVEL_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET   = 8'h00;
  localparam logic [7:0] OPEN_DRAIN_RESET  = 8'h00;
  localparam logic [7:0] HIGH_Z_RESET      = 8'h00;

  localparam int unsigned SYNC_STAGES = 2;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              page;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gxp_req_t;

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] dir;
    logic [7:0] open_drain;
    logic [7:0] high_z;
  } gxp_cfg_t;
endpackage
`default_nettype wire

// File: src/gxp_sync.sv
/*
  two-stage synchroniser for the pin inputs, one bit per pin.
  assumes pins are asynchronous to clk_in; the first stage feeds only the second.
*/
`default_nettype none
module gxp_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else if (clk_en_in) begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule
`default_nettype wire

// File: src/gxp_port.sv
/*
  eight-pin general-purpose port: direction, output level, output type and input state
  registers, pin drive logic and a level readback through a two-stage synchroniser.
  assumes a register port from the device's serial front end carrying a page bit;
  pad cells resolve the wire from the drive/enable/pull-down outputs.
*/
//
// Function
// - A write-only output-level register on page one sets each pin's driven level in bits 7:0, default low.
// - The stored output level reaches a pin only when that pin is configured as an output.
// - The output-level register never reads back; the pin level register gives the real level.
// - The direction register holds one bit per pin in bits 15:8, 0 input by default, 1 output.
// - The output-type register holds one bit per pin in bits 15:8, 0 push-pull by default, 1 open-drain.
// - The output type affects only pins configured as outputs.
// - The input-state register holds one bit per pin in bits 15:8, 0 pull-down by default, 1 high-impedance.
// - The input state affects only pins configured as inputs.
// - The read-only pin level register on page zero reports every pin's level in bits 7:0 whatever its direction.
// - Reads of the pin level register return zero in bits 15:8.
// - The shared address reads pin levels on page zero and takes output-level writes on page one.
// - After reset every pin is an input with its weak pull-down selected.
`default_nettype none
module gxp_port #(
  parameter int unsigned PINS = gxp_pkg::PIN_COUNT
) (
  input  wire logic                        clk_in,
  input  wire logic                        reset_n_in,
  input  wire logic                        clk_en_in,
  input  wire gxp_pkg::gxp_req_t           req_in,
  output logic [gxp_pkg::DATA_W-1:0]       rdata_out,
  output logic                             rvalid_out,
  input  wire logic [PINS-1:0]             pin_in,
  output logic      [PINS-1:0]             pin_out,
  output logic      [PINS-1:0]             pin_oe_out,
  output logic      [PINS-1:0]             pin_pulldown_out
);
  gxp_pkg::gxp_cfg_t          cfg;
  logic [7:0]                 drive_reg;
  logic [7:0]                 dir_reg;
  logic [7:0]                 open_drain_reg;
  logic [7:0]                 high_z_reg;
  logic [PINS-1:0]            level_sync;
  logic                       wr_taken;
  logic                       rd_taken;
  logic                       wr_level;
  logic                       wr_dir;
  logic                       wr_out_type;
  logic                       wr_in_state;
  logic                       rd_level;
  logic                       rd_dir;
  logic                       rd_out_type;
  logic                       rd_in_state;
  logic [gxp_pkg::DATA_W-1:0] rdata_next;
  logic [PINS-1:0]            pin_out_next;
  logic [PINS-1:0]            pin_oe_next;
  logic [PINS-1:0]            pin_pulldown_next;

  // register selected by page and index
  function automatic logic hit(input gxp_pkg::gxp_req_t r, input logic pg, input logic [4:0] a);
    hit = (r.page == pg) && (r.addr == a);
  endfunction

  // per-pin control byte in the upper field
  function automatic logic [7:0] high_field(input logic [gxp_pkg::DATA_W-1:0] w);
    high_field = w[gxp_pkg::HIGH_FIELD_LSB +: 8];
  endfunction

  function automatic logic [7:0] low_field(input logic [gxp_pkg::DATA_W-1:0] w);
    low_field = w[gxp_pkg::LOW_FIELD_LSB +: 8];
  endfunction

  // read word with the byte in the upper field, reserved bits zero
  function automatic logic [gxp_pkg::DATA_W-1:0] put_high(input logic [7:0] b);
    put_high = '0;
    put_high[gxp_pkg::HIGH_FIELD_LSB +: 8] = b;
  endfunction

  function automatic logic [gxp_pkg::DATA_W-1:0] put_low(input logic [7:0] b);
    put_low = '0;
    put_low[gxp_pkg::LOW_FIELD_LSB +: 8] = b;
  endfunction

  // push-pull follows the level; open-drain only ever pulls low
  function automatic logic drive_value(input logic dir, input logic od, input logic lvl);
    drive_value = dir & lvl & ~od;
  endfunction

  function automatic logic drive_enable(input logic dir, input logic od, input logic lvl);
    drive_enable = dir & (~od | ~lvl);
  endfunction

  // pull-down only on inputs left in the pull-down state
  function automatic logic pull_enable(input logic dir, input logic hz);
    pull_enable = ~dir & ~hz;
  endfunction

  gxp_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   (pin_in),
    .sync_out   (level_sync)
  );

  assign cfg = '{drive: drive_reg, dir: dir_reg, open_drain: open_drain_reg, high_z: high_z_reg};

  assign wr_taken = clk_en_in & req_in.wr;
  assign rd_taken = clk_en_in & req_in.rd;

  // write decode; page zero writes and unmapped indices fall through
  always_comb begin
    wr_level    = 1'h0;
    wr_dir      = 1'h0;
    wr_out_type = 1'h0;
    wr_in_state = 1'h0;
    if (wr_taken && hit(req_in, gxp_pkg::PAGE_CONTROL, gxp_pkg::ADDR_LEVEL)) begin
      wr_level = 1'h1;
    end else if (wr_taken && hit(req_in, gxp_pkg::PAGE_CONTROL, gxp_pkg::ADDR_DIR)) begin
      wr_dir = 1'h1;
    end else if (wr_taken && hit(req_in, gxp_pkg::PAGE_CONTROL, gxp_pkg::ADDR_OUT_TYPE)) begin
      wr_out_type = 1'h1;
    end else if (wr_taken && hit(req_in, gxp_pkg::PAGE_CONTROL, gxp_pkg::ADDR_IN_STATE)) begin
      wr_in_state = 1'h1;
    end
  end

  // read decode; the shared index reads levels on page zero only
  always_comb begin
    rd_level    = 1'h0;
    rd_dir      = 1'h0;
    rd_out_type = 1'h0;
    rd_in_state = 1'h0;
    if (rd_taken && hit(req_in, gxp_pkg::PAGE_STATUS, gxp_pkg::ADDR_LEVEL)) begin
      rd_level = 1'h1;
    end else if (rd_taken && hit(req_in, gxp_pkg::PAGE_CONTROL, gxp_pkg::ADDR_DIR)) begin
      rd_dir = 1'h1;
    end else if (rd_taken && hit(req_in, gxp_pkg::PAGE_CONTROL, gxp_pkg::ADDR_OUT_TYPE)) begin
      rd_out_type = 1'h1;
    end else if (rd_taken && hit(req_in, gxp_pkg::PAGE_CONTROL, gxp_pkg::ADDR_IN_STATE)) begin
      rd_in_state = 1'h1;
    end
  end

  // read data; the write-only level register has no readback path
  always_comb begin
    rdata_next = '0;
    if (rd_level) begin
      rdata_next = put_low(level_sync);
    end else if (rd_dir) begin
      rdata_next = put_high(cfg.dir);
    end else if (rd_out_type) begin
      rdata_next = put_high(cfg.open_drain);
    end else if (rd_in_state) begin
      rdata_next = put_high(cfg.high_z);
    end
  end

  // output level, write-only
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_reg <= gxp_pkg::DRIVE_LEVEL_RESET;
    end else if (wr_level) begin
      drive_reg <= low_field(req_in.wdata);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir_reg <= gxp_pkg::DIRECTION_RESET;
    end else if (wr_dir) begin
      dir_reg <= high_field(req_in.wdata);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      open_drain_reg <= gxp_pkg::OPEN_DRAIN_RESET;
    end else if (wr_out_type) begin
      open_drain_reg <= high_field(req_in.wdata);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      high_z_reg <= gxp_pkg::HIGH_Z_RESET;
    end else if (wr_in_state) begin
      high_z_reg <= high_field(req_in.wdata);
    end
  end

  // read strobe answered one edge later
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rvalid_out <= 1'h0;
    end else if (clk_en_in) begin
      rvalid_out <= req_in.rd;
    end
  end

  // read data held until the next taken read
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= '0;
    end else if (rd_taken) begin
      rdata_out <= rdata_next;
    end
  end

  always_comb begin
    pin_out_next      = '0;
    pin_oe_next       = '0;
    pin_pulldown_next = '0;
    for (int i = 0; i < PINS; i++) begin
      pin_out_next[i]      = drive_value(cfg.dir[i], cfg.open_drain[i], cfg.drive[i]);
      pin_oe_next[i]       = drive_enable(cfg.dir[i], cfg.open_drain[i], cfg.drive[i]);
      pin_pulldown_next[i] = pull_enable(cfg.dir[i], cfg.high_z[i]);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_out <= '0;
    end else if (clk_en_in) begin
      pin_out <= pin_out_next;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_oe_out <= '0;
    end else if (clk_en_in) begin
      pin_oe_out <= pin_oe_next;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_pulldown_out <= '1;
    end else if (clk_en_in) begin
      pin_pulldown_out <= pin_pulldown_next;
    end
  end
endmodule
`default_nettype wire

// File: bench/gxp_port_sva.sv
/* checker for gxp_port, bound to each instance.
   assumes clk_en_in stays high around level reads. */
`default_nettype none
module gxp_port_sva #(parameter int unsigned PINS = 8) (
  input wire logic                       clk_in,
  input wire logic                       reset_n_in,
  input wire logic                       clk_en_in,
  input wire gxp_pkg::gxp_req_t          req_in,
  input wire logic [gxp_pkg::DATA_W-1:0] rdata_out,
  input wire logic                       rvalid_out,
  input wire logic [PINS-1:0]            pin_in,
  input wire logic [PINS-1:0]            pin_out,
  input wire logic [PINS-1:0]            pin_oe_out,
  input wire logic [PINS-1:0]            pin_pulldown_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic rd_on, lvl_rd;
  assign rd_on = clk_en_in && req_in.rd;
  assign lvl_rd = rd_on && !req_in.page && req_in.addr == gxp_pkg::ADDR_LEVEL;
  a_read_answer: assert property (rd_on |=> rvalid_out) else $error("read not answered");
  a_level_high_zero: assert property (lvl_rd |=> rdata_out[15:8] == 8'h00) else $error("level high bits set");
  a_level_synced: assert property (lvl_rd && $past(clk_en_in) && $past(clk_en_in, 2) |=>
    rdata_out[7:0] == $past(pin_in, 3))
    else $error("level not synchronised");
  a_wo_no_read: assert property (rd_on && req_in.page && req_in.addr == gxp_pkg::ADDR_LEVEL |=> rdata_out == '0)
    else $error("output level read back");
  a_drive_needs_oe: assert property ((pin_out & ~pin_oe_out) == '0) else $error("drive without enable");
  a_pull_inputs: assert property ((pin_pulldown_out & pin_oe_out) == '0) else $error("pull-down on output");
  a_reset_inputs: assert property ($rose(reset_n_in) |-> pin_oe_out == '0 && pin_pulldown_out == '1)
    else $error("pins not inputs after reset");
  a_inputs_undriven: assert property (clk_en_in && req_in.wr && req_in.page && req_in.addr == gxp_pkg::ADDR_DIR
    && req_in.wdata[15:8] == 8'h00 |-> ##2 pin_oe_out == '0) else $error("input pin driven");
endmodule
bind gxp_port gxp_port_sva #(.PINS(PINS)) u_sva (.*);
`default_nettype wire

// File: bench/gxp_pins_model.sv
/* pads and board around the eight pins.
   assumes a weak board source that the pull-down overrides. */
`default_nettype none
module gxp_pins_model (
  input  wire logic [7:0] drive_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pull_in,
  input  wire logic [7:0] ext_in,
  output logic      [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level_out = (oe_in & drive_in) | (~oe_in & ~pull_in & ext_in);
endmodule
`default_nettype wire

// File: bench/tb_gxp_port.sv
/* testbench for gxp_port: register access, pin drive and readback.
   assumes gxp_pins_model resolves the pin wires. */
`default_nettype none
module tb_gxp_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_in = 1'h0;
  logic              reset_n_in = 1'h0;
  logic              en = 1'h1;
  gxp_pkg::gxp_req_t req = '0;
  logic [15:0]       rdata;
  logic              rv;
  logic [7:0]        lvl, drv, oe, pd;
  logic [7:0]        ext = 8'hFF;
  int                n_errors = 0, compares = 0, cycles = 0;
  always #10 clk_in = ~clk_in;
  gxp_port u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(en), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rv), .pin_in(lvl), .pin_out(drv), .pin_oe_out(oe), .pin_pulldown_out(pd));
  gxp_pins_model u_pins (.drive_in(drv), .oe_in(oe), .pull_in(pd), .ext_in(ext), .level_out(lvl));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic p, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req <= '{wr: w, rd: ~w, page: p, addr: a, wdata: d};
    @(posedge clk_in);
    req <= '0;
    #1;
    if (!w) chk("rvalid", 16'h0001, {15'h0, rv});
  endtask
  task automatic rd(input logic p, input logic [4:0] a, input logic [15:0] e);
    acc(1'h0, p, a, 16'h0);
    chk("rdata", e, rdata);
  endtask
  task automatic pins(input logic [7:0] d, input logic [7:0] o, input logic [7:0] u);
    repeat (4) @(posedge clk_in);
    #1;
    chk("pins", {d, o}, {drv, oe});
    chk("pulldown", {8'h0, u}, {8'h0, pd});
  endtask
  task automatic t_reset();
    pins(8'h0, 8'h0, 8'hFF);
    rd(1'h1, 5'h11, 16'h0);
    rd(1'h1, 5'h12, 16'h0);
    rd(1'h1, 5'h13, 16'h0);
  endtask
  task automatic t_push_pull();
    acc(1'h1, 1'h1, 5'h10, 16'h00AA);
    acc(1'h1, 1'h1, 5'h11, 16'hFF00);
    pins(8'hAA, 8'hFF, 8'h00);
    rd(1'h0, 5'h10, 16'h00AA);
    rd(1'h1, 5'h10, 16'h0);
  endtask
  task automatic t_open_drain();
    acc(1'h1, 1'h1, 5'h12, 16'hF000);
    pins(8'h0A, 8'h5F, 8'h00);
    rd(1'h0, 5'h10, 16'h00AA);
    @(posedge clk_in);
    ext <= 8'h00;
    // two edges through the synchroniser
    repeat (2) @(posedge clk_in);
    rd(1'h0, 5'h10, 16'h000A);
  endtask
  task automatic t_input();
    @(posedge clk_in);
    ext <= 8'hC0;
    acc(1'h1, 1'h1, 5'h11, 16'h0F00);
    acc(1'h1, 1'h1, 5'h13, 16'hC000);
    pins(8'h0A, 8'h0F, 8'h30);
    rd(1'h0, 5'h10, 16'h00CA);
    acc(1'h1, 1'h0, 5'h11, 16'h0);
    rd(1'h1, 5'h11, 16'h0F00);
    acc(1'h1, 1'h1, 5'h11, 16'h0);
    pins(8'h00, 8'h00, 8'h3F);
  endtask
  // clock enable low: write ignored, pins frozen
  task automatic t_hold();
    @(posedge clk_in);
    en <= 1'h0;
    acc(1'h1, 1'h1, 5'h13, 16'hFF00);
    pins(8'h00, 8'h00, 8'h3F);
    @(posedge clk_in);
    en <= 1'h1;
    rd(1'h1, 5'h13, 16'hC000);
  endtask
  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'h1;
    t_reset();
    t_push_pull();
    t_open_drain();
    t_input();
    t_hold();
    give_verdict();
  end
endmodule
`default_nettype wire
